// file: pkg/bsm_cfg.svh
`ifndef BSM_CFG_SVH
`define BSM_CFG_SVH
// ==========================================================================
// Register map.
// ==========================================================================
// Converter pair B status register byte address.
`define BSM_ADDR_PAIR_B_STAT   8'h1D
// Global event mask register byte address.
`define BSM_ADDR_EVENT_MASK    8'h1E
// ==========================================================================
// Field positions.
// ==========================================================================
`define BSM_BIT_C3_PG          6
`define BSM_BIT_C3_ILIM        4
`define BSM_BIT_C2_EN          3
`define BSM_BIT_C2_PG          2
`define BSM_BIT_C2_ILIM        0
`define BSM_BIT_TW_MASK        2
`define BSM_BIT_RR_MASK        1
`define BSM_BIT_LR_MASK        0
// ==========================================================================
// Reset values.
// ==========================================================================
// Register-reset interrupt starts masked; the others start enabled.
`define BSM_RST_EVENT_MASK     8'h02
`define BSM_RST_PAIR_B_STAT    8'h00
`endif

// file: pkg/bsm_pkg.sv
// ==========================================================================
// Shared types for the converter status and top mask block.
// ==========================================================================
package bsm_pkg;
  // Raw analogue conditions for converters two and three.
  typedef struct packed {
    logic conv3PowerLow;   // Converter three below power-good threshold.
    logic conv3CurLimit;   // Converter three in current limit.
    logic conv2Enabled;    // Converter two core enabled.
    logic conv2PowerLow;   // Converter two below power-good threshold.
    logic conv2CurLimit;   // Converter two in current limit.
  } bsm_conv_s;
  // Top-level pending interrupt sources.
  typedef struct packed {
    logic thermalWarn;     // Thermal-warning interrupt flag pending.
    logic regReset;        // Register-reset interrupt flag pending.
    logic loadReady;       // Load-current-ready interrupt flag pending.
  } bsm_pend_s;
  typedef logic [7:0] bsm_byte_t;
endpackage : bsm_pkg

// file: src/bsm_status_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_cfg.svh"
module bsm_status_mask (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire bsm_pkg::bsm_conv_s  convRaw,
  input  wire logic                dieOverWarn,
  input  wire bsm_pkg::bsm_pend_s  pending,
  input  wire logic                regWrite,
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWdata,
  output logic [7:0]               regRdata,
  output logic                     thermalWarningStatus,
  output logic                     interruptOutN
);

  // ========================================================================
  // Input synchronisers.
  // ========================================================================
  // Analogue comparators are asynchronous to the clock, so each condition
  // passes two flops before anything reads it.
  // The price is two cycles of lag on every status bit, which is far below
  // any rate at which a host could poll the registers.
  bsm_pkg::bsm_conv_s convMeta_reg;   // First stage, read only by stage two.
  bsm_pkg::bsm_conv_s convSync_reg;   // Stable converter conditions.
  logic               dieMeta_reg;    // First stage of die comparator.
  logic               dieSync_reg;    // Stable die comparator.

  // Two-flop synchroniser for all raw conditions.
  always_ff @(posedge clock) begin
    if (reset) begin
      // Clear both stages so no stale condition shows after reset.
      convMeta_reg <= '0;
      convSync_reg <= '0;
      dieMeta_reg  <= 1'b0;
      dieSync_reg  <= 1'b0;
    end else begin
      // Shift every condition one stage further.
      convMeta_reg <= convRaw;
      convSync_reg <= convMeta_reg;
      dieMeta_reg  <= dieOverWarn;
      dieSync_reg  <= dieMeta_reg;
    end
  end

  // ========================================================================
  // Register decode.
  // ========================================================================
  // Address compare shared by the write and the read path, so the two can
  // never disagree on where a register lives.
  function automatic logic addrMatch(input bsm_pkg::bsm_byte_t addr,
                                     input bsm_pkg::bsm_byte_t target);
    return addr == target;
  endfunction : addrMatch

  // Only the mask register is writable; the status register ignores writes.
  wire maskSel = addrMatch(regAddr, `BSM_ADDR_EVENT_MASK);   // Mask register addressed.
  wire statHit = addrMatch(regAddr, `BSM_ADDR_PAIR_B_STAT);  // Status register addressed.
  wire maskHit = regWrite && maskSel;                         // Write strobe for the mask.

  bsm_pkg::bsm_byte_t eventMask_reg;   // Global event mask register.
  bsm_pkg::bsm_byte_t statusByte;      // Assembled status byte.

  // Reserved bits 5, 1 and 7 read zero; nothing drives bit 7.
  // The byte is a plain view of the synchronised levels; nothing latches
  // here, so a condition shorter than a poll interval can go unseen.
  always_comb begin
    statusByte                   = '0;
    statusByte[`BSM_BIT_C3_PG]   = convSync_reg.conv3PowerLow;
    statusByte[`BSM_BIT_C3_ILIM] = convSync_reg.conv3CurLimit;
    statusByte[`BSM_BIT_C2_EN]   = convSync_reg.conv2Enabled;
    statusByte[`BSM_BIT_C2_PG]   = convSync_reg.conv2PowerLow;
    statusByte[`BSM_BIT_C2_ILIM] = convSync_reg.conv2CurLimit;
  end

  // Read mux; unmapped addresses read zero.
  // Registering the result keeps regRdata glitch free, at the price of one
  // cycle between the address and its data.
  wire bsm_pkg::bsm_byte_t rdNext = statHit ? statusByte :
                                    maskSel ? eventMask_reg : 8'h00;

  // ========================================================================
  // Mask register and read data.
  // ========================================================================
  // All eight bits are read/write; the reserved upper bits simply store, so
  // software reading the mask back always sees what it wrote.
  always_ff @(posedge clock) begin
    if (reset) begin
      // Register-reset source starts blocked; the other two start open.
      eventMask_reg <= `BSM_RST_EVENT_MASK;
      regRdata      <= 8'h00;
    end else begin
      // A write lands on the edge that sees the strobe.
      if (maskHit) begin
        eventMask_reg <= regWdata;
      end
      // Read data follows the address one cycle late.
      regRdata <= rdNext;
    end
  end

  // ========================================================================
  // Interrupt gating.
  // ========================================================================
  // Masks act only on the interrupt path; flags and status stay untouched.
  // The pending struct packs thermal warning, register reset and load ready
  // from the top bit down; the table below names the mask bit of each source.
  localparam int unsigned gateMaskBit [3] = '{`BSM_BIT_LR_MASK, `BSM_BIT_RR_MASK,
                                              `BSM_BIT_TW_MASK};
  wire logic [2:0] pendVec = pending;   // Pending flags as a plain vector.
  wire logic [2:0] srcGated;            // Sources that survive their mask.

  // One gate per source; a set mask bit blocks that source and no other.
  for (genvar g = 0; g < 3; g++) begin : g_gate
    assign srcGated[g] = pendVec[g] & ~eventMask_reg[gateMaskBit[g]];
  end

  // Any surviving source pulls the pin low.
  wire irqNext = |srcGated;

  // The pending inputs come from same-clock flag logic, so no sync here.
  // The pin is registered to keep it glitch free, costing one cycle.
  // A flag that is set and cleared again within one cycle may never reach
  // the pin; the flag logic outside is expected to hold flags until read.
  always_ff @(posedge clock) begin
    if (reset) begin
      // Pin released and status clear while in reset.
      interruptOutN        <= 1'b1;
      thermalWarningStatus <= 1'b0;
    end else begin
      // The status comes from the comparator alone, so no mask can hide it.
      interruptOutN        <= ~irqNext;
      thermalWarningStatus <= dieSync_reg;
    end
  end

  // ========================================================================
  // Assertions.
  // ========================================================================
  a_mask_reset_value: assert property (@(posedge clock)
    $fell(reset) |-> eventMask_reg == 8'h02)
    else $error("Mask register reset value wrong.");
  a_thermal_irq_gate: assert property (@(posedge clock) disable iff (reset)
    (pending.thermalWarn && !eventMask_reg[2] && !reset) |=> !interruptOutN)
    else $error("Unmasked thermal warning did not drive interrupt.");
  a_reset_irq_gate: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b010 && eventMask_reg[1]) |=> interruptOutN)
    else $error("Masked register-reset interrupt reached the pin.");
  a_load_irq_gate: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b001 && !eventMask_reg[0]) |=> !interruptOutN)
    else $error("Unmasked load-ready did not drive interrupt.");
  a_irq_release: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b000) |=> interruptOutN)
    else $error("Interrupt held with nothing pending.");
  // The status follows the second synchroniser stage one cycle later.
  a_thermal_status: assert property (@(posedge clock) disable iff (reset)
    $rose(dieSync_reg) |=> thermalWarningStatus)
    else $error("Thermal status did not follow die comparator.");
  a_thermal_unmasked: assert property (@(posedge clock) disable iff (reset)
    (eventMask_reg[2] && dieSync_reg) |=> thermalWarningStatus)
    else $error("Thermal mask suppressed the status bit.");
  a_stat_c3_pg: assert property (@(posedge clock) disable iff (reset)
    (statHit && convSync_reg.conv3PowerLow) |=> regRdata[6])
    else $error("Converter three power-good bit wrong.");
  a_stat_c3_ilim: assert property (@(posedge clock) disable iff (reset)
    (statHit && !convSync_reg.conv3CurLimit) |=> !regRdata[4])
    else $error("Converter three current-limit bit wrong.");
  a_stat_c2_en: assert property (@(posedge clock) disable iff (reset)
    statHit |=> regRdata[3] == $past(convSync_reg.conv2Enabled))
    else $error("Converter two enable bit wrong.");
  a_stat_c2_pg: assert property (@(posedge clock) disable iff (reset)
    statHit |=> regRdata[2] == $past(convSync_reg.conv2PowerLow))
    else $error("Converter two power-good bit wrong.");
  a_stat_c2_ilim: assert property (@(posedge clock) disable iff (reset)
    statHit |=> regRdata[0] == $past(convSync_reg.conv2CurLimit) && !regRdata[1])
    else $error("Converter two current-limit bit wrong.");

  // Further checks on the mask register and the pin.
  a_mask_write_lands: assert property (@(posedge clock) disable iff (reset)
    maskHit |=> eventMask_reg == $past(regWdata))
    else $error("Mask write did not land.");
  a_reset_irq_open: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b010 && !eventMask_reg[`BSM_BIT_RR_MASK]) |=> !interruptOutN)
    else $error("Unmasked register-reset interrupt did not drive interrupt.");
  a_thermal_masked_pin: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b100 && eventMask_reg[`BSM_BIT_TW_MASK]) |=> interruptOutN)
    else $error("Masked thermal warning reached the pin.");
  a_load_masked_pin: assert property (@(posedge clock) disable iff (reset)
    (pending == 3'b001 && eventMask_reg[`BSM_BIT_LR_MASK]) |=> interruptOutN)
    else $error("Masked load-ready interrupt reached the pin.");
  // Thermal status must drop again once the die cools below the level.
  a_thermal_clear: assert property (@(posedge clock) disable iff (reset)
    $fell(dieSync_reg) |=> !thermalWarningStatus)
    else $error("Thermal status did not clear.");
  // Reset checks carry no disable clause, since reset is what they watch.
  a_reset_outputs: assert property (@(posedge clock)
    reset |=> interruptOutN && !thermalWarningStatus && regRdata == 8'h00)
    else $error("Outputs not at reset values after reset.");

  // Main scenarios that a run should reach.
  c_mask_write: cover property (@(posedge clock) maskHit);
  c_irq_assert: cover property (@(posedge clock) $fell(interruptOutN));
  c_masked_thermal: cover property (@(posedge clock)
    pending.thermalWarn && eventMask_reg[2]);
  c_status_read: cover property (@(posedge clock) statHit && convSync_reg != '0);
  c_load_irq: cover property (@(posedge clock)
    pending.loadReady && !eventMask_reg[`BSM_BIT_LR_MASK]);

endmodule : bsm_status_mask
`default_nettype wire

// file: verif/bsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host model: drives the block's register port, one byte per access.
// ==========================================================================
module bsm_host_model (
  input  wire logic       clock,
  output logic            regWrite,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWdata,
  input  wire logic [7:0] regRdata
);
  // Idle bus at start: no strobe, address and data at zero.
  initial begin
    regWrite = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end
  // One-cycle write strobe; the data is inverted after, so a late sample shows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask : wr
  // Read data is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    @(posedge clock);
    #1 d = regRdata;
  endtask : rd
endmodule : bsm_host_model
`default_nettype wire

// file: verif/bsm_status_mask_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_cfg.svh"
// ==========================================================================
// Self-checking bench for the status and top mask block.
// ==========================================================================
module bsm_status_mask_tb_top;
  logic               clock       = 1'b0;
  logic               reset       = 1'b1;
  bsm_pkg::bsm_conv_s convRaw     = '0;
  logic               dieOverWarn = 1'b0;
  bsm_pkg::bsm_pend_s pending     = '0;
  logic               regWrite;
  logic [7:0]         regAddr;
  logic [7:0]         regWdata;
  logic [7:0]         regRdata;
  logic               thermalWarningStatus;
  logic               interruptOutN;
  logic [7:0]         rd;
  int                 bad_count   = 0;
  int                 comparisons = 0;
  int                 cycles      = 0;
  // Status bit on which each raw condition lands, lowest struct bit first.
  int                 pos[5]      = '{`BSM_BIT_C2_ILIM, `BSM_BIT_C2_PG, `BSM_BIT_C2_EN,
                                      `BSM_BIT_C3_ILIM, `BSM_BIT_C3_PG};
  initial begin
    forever #4 clock = ~clock;
  end
  bsm_status_mask u_bsm_status_mask (.clock(clock), .reset(reset), .convRaw(convRaw),
    .dieOverWarn(dieOverWarn), .pending(pending), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .thermalWarningStatus(thermalWarningStatus),
    .interruptOutN(interruptOutN));
  bsm_host_model u_bsm_host_model (.clock(clock), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  // Compares one byte and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // Sets the pending flags and checks the pin one edge later.
  task automatic pin(input logic [2:0] p, input logic e);
    @(posedge clock);
    pending <= p;
    @(posedge clock);
    #1 check({7'h00, interruptOutN}, {7'h00, e});
  endtask : pin
  task automatic finish_test();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Cuts a hang short well above the expected run length.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    u_bsm_host_model.rd(`BSM_ADDR_EVENT_MASK, rd); check(rd, 8'h02);
    u_bsm_host_model.rd(`BSM_ADDR_PAIR_B_STAT, rd); check(rd, 8'h00);
    // Each raw condition alone must land on its own status bit.
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      convRaw <= bsm_pkg::bsm_conv_s'(5'h01 << i);
      repeat (4) @(posedge clock);
      u_bsm_host_model.rd(`BSM_ADDR_PAIR_B_STAT, rd); check(rd, 8'h01 << pos[i]);
    end
    @(posedge clock);
    convRaw <= '0;
    u_bsm_host_model.wr(`BSM_ADDR_PAIR_B_STAT, 8'hFF);
    u_bsm_host_model.rd(`BSM_ADDR_PAIR_B_STAT, rd); check(rd, 8'h00);
    u_bsm_host_model.rd(8'h55, rd); check(rd, 8'h00);
    pin(3'b010, 1'b1);
    pin(3'b001, 1'b0);
    pin(3'b000, 1'b1);
    pin(3'b100, 1'b0);
    u_bsm_host_model.wr(`BSM_ADDR_EVENT_MASK, 8'h04);
    pin(3'b100, 1'b1);
    @(posedge clock);
    dieOverWarn <= 1'b1;
    repeat (5) @(posedge clock);
    #1 check({7'h00, thermalWarningStatus}, 8'h01);
    @(posedge clock);
    dieOverWarn <= 1'b0;
    u_bsm_host_model.wr(`BSM_ADDR_EVENT_MASK, 8'h00);
    pin(3'b010, 1'b0);
    u_bsm_host_model.wr(`BSM_ADDR_EVENT_MASK, 8'h01);
    pin(3'b001, 1'b1);
    check({7'h00, thermalWarningStatus}, 8'h00);
    u_bsm_host_model.wr(`BSM_ADDR_EVENT_MASK, 8'hFF);
    u_bsm_host_model.rd(`BSM_ADDR_EVENT_MASK, rd); check(rd, 8'hFF);
    // A second reset in mid-run must restore the mask default.
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    u_bsm_host_model.rd(`BSM_ADDR_EVENT_MASK, rd); check(rd, 8'h02);
    finish_test();
  end
endmodule : bsm_status_mask_tb_top
`default_nettype wire
